// >>> logic/rtc_cfg.svh
// constants of the reloadable timer: register offsets, field positions,
// reset values and fixed counts; definitions only
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// byte offsets on the register bus, one aligned 32-bit word each
`define RTC_ADDR_W        8
`define RTC_OFF_CTRL      8'h00
`define RTC_OFF_COUNT     8'h04
`define RTC_OFF_RELOAD    8'h08
`define RTC_OFF_STATUS    8'h0c

// control register fields
`define RTC_CTRL_EN       0
`define RTC_CTRL_MODE_LO  1
`define RTC_CTRL_MODE_HI  2
`define RTC_CTRL_POL      3
`define RTC_CTRL_PRE_LO   4
`define RTC_CTRL_PRE_HI   6
`define RTC_CTRL_OUTEN    7

// status register fields
`define RTC_STAT_SEEN     0
`define RTC_STAT_LEVEL    1
`define RTC_STAT_EN       2

// reset and reload values
`define RTC_COUNT_RST     16'h0000
`define RTC_RELOAD_RST    16'h0000
`define RTC_COUNT_RESTART 16'h0001
`define RTC_PRE_RST       3'h0

// number of sampled count inputs: timer input pin and comparator
`define RTC_NUM_SRC       2
`define RTC_SRC_PIN       0
`define RTC_SRC_CMP       1

`endif

// >>> logic/rtc_edge.sv
// two-flop synchroniser plus edge detect for one count input
// assumes the input toggles no faster than a quarter of the clock
`timescale 1ns/1ps
module rtc_edge (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      rise,
	output logic      fall
);

	logic [2:0] sh_r;
	logic [2:0] sh_nxt;

	// sh_r[0] is the metastable stage, read only by sh_r[1]
	always_comb begin
		sh_nxt = {sh_r[1:0], din};
		rise   = sh_r[1] && !sh_r[2];
		fall   = !sh_r[1] && sh_r[2];
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sh_r <= 3'h0;
		end else begin
			sh_r <= sh_nxt;
		end
	end

endmodule

// >>> logic/rtc_pkg.sv
// types of the reloadable timer
// assumes rtc_cfg.svh for all numeric constants
package rtc_pkg;

	typedef enum logic [1:0] {
		RTC_ONE_SHOT   = 2'b00,
		RTC_CONTINUOUS = 2'b01,
		RTC_COUNTER    = 2'b10,
		RTC_CMP_COUNT  = 2'b11
	} rtc_mode_t;

	typedef struct packed {
		logic        en;
		rtc_mode_t   mode;
		logic        pol;
		logic [2:0]  pre;
		logic        out_en;
		logic [15:0] count;
		logic [15:0] reload;
		logic        seen;
		logic        level;
		logic        tout;
		logic        irq;
		logic        waitreq;
		logic [31:0] rdata;
	} rtc_state_t;

endpackage

// >>> logic/rtc_prescale.sv
// prescaler: one tick every 2**exp clocks while run is high
// assumes asynchronous active-low reset from the parent, released synchronously there
`timescale 1ns/1ps
module rtc_prescale (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [2:0] exp_sel,
	output logic            tick
);

	logic [6:0] cnt_r;
	logic [6:0] cnt_nxt;
	logic [6:0] limit;

	// divide values 1 .. 128 as powers of two
	always_comb begin
		limit   = 7'((8'h01 << exp_sel) - 8'h01);
		tick    = run && (cnt_r == limit);
		cnt_nxt = (!run || tick) ? 7'h00 : 7'(cnt_r + 7'h01);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 7'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

// >>> logic/rtc_timer.sv
// reloadable 16-bit timer with one-shot, continuous and two edge-count modes
// assumes an Avalon-MM master, a timer input pin and a comparator output
//
// Behaviour
// R1 - one-shot: at reload raise interrupt, count to 0001H, clear enable, stop
// R2 - one-shot with output on: invert output pin for exactly one clock at reload
// R3 - software writes inverse polarity after start for a lasting one-shot level
// R4 - continuous: at reload raise interrupt, count to 0001H, keep counting
// R5 - repeating modes with output on: toggle output at each reload, hold it
// R6 - written start count only for first pass; later passes start at 0001H
// R7 - one-shot and continuous count the prescaled system clock
// R8 - continuous period is reload times prescale clocks
// R9 - counter mode counts selected edge of timer input; polarity picks edge
// R10 - edge-counting modes bypass prescaler, one step per qualifying edge
// R11 - timer input must not toggle faster than a quarter of the clock
// R12 - software loads count with 0001H before enabling counter mode
// R13 - comparator mode counts selected edge of comparator output
// R14 - comparator output must not toggle faster than a quarter of the clock
// R15 - edge select also sets initial output level; output need not be on
// R16 - count register reads live count in counter mode
// R17 - software disables, configures, then enables the timer last
// R18 - prescaler divides system clock by 1 up to 128
// R19 - count wraps from FFFFH to 0000H and continues
// R20 - count inputs synchronised and edge detected from successive samples
// R21 - reload detected by full 16-bit equality when the count advances
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_timer (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        timer_in,
	input  wire logic        cmp_out,
	output logic             timer_out,
	output logic             timer_out_oe,
	output logic             timer_irq
);

	// {valid, word index}; anything above the four words is unmapped
	function automatic logic [2:0] rtc_decode(input logic [7:0] addr);
		logic [2:0] res;
		res = {(addr[7:4] == 4'h0), addr[3:2]};
		return res;
	endfunction

	// byte-lane merge of the low 16 bits
	function automatic logic [15:0] rtc_merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	logic                   rst_meta_r;
	logic                   rst_sync_n;
	rtc_pkg::rtc_state_t    s_r;
	rtc_pkg::rtc_state_t    s_nxt;
	logic                   pre_tick;
	logic                   clocked_mode;
	logic                   edge_hit;
	logic                   adv;
	logic                   hit;
	logic                   wr_fire;
	logic [2:0]             wr_dec;
	logic [2:0]             rd_dec;
	logic [`RTC_NUM_SRC-1:0] src_in;
	logic [`RTC_NUM_SRC-1:0] src_rise;
	logic [`RTC_NUM_SRC-1:0] src_fall;

	// reset released through two flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	assign clocked_mode = (s_r.mode == rtc_pkg::RTC_ONE_SHOT) ||
		(s_r.mode == rtc_pkg::RTC_CONTINUOUS);

	// prescaler held cleared by run low while idle so each start begins a full division
	rtc_prescale u_pre (
		.clock   (clock),
		.rst_n   (rst_sync_n),
		.run     (s_r.en && clocked_mode), // R7
		.exp_sel (s_r.pre),                // R18
		.tick    (pre_tick)
	);

	assign src_in[`RTC_SRC_PIN] = timer_in;
	assign src_in[`RTC_SRC_CMP] = cmp_out;

	generate
		for (genvar gi = 0; gi < `RTC_NUM_SRC; gi++) begin : g_src
			rtc_edge u_edge ( // R20
				.clock (clock),
				.rst_n (rst_sync_n),
				.din   (src_in[gi]),
				.rise  (src_rise[gi]),
				.fall  (src_fall[gi])
			);
		end
	endgenerate

	always_comb begin
		// polarity high counts rising edges
		if (s_r.mode == rtc_pkg::RTC_COUNTER) begin
			edge_hit = s_r.pol ? src_rise[`RTC_SRC_PIN] : src_fall[`RTC_SRC_PIN]; // R9
		end else begin
			edge_hit = s_r.pol ? src_rise[`RTC_SRC_CMP] : src_fall[`RTC_SRC_CMP]; // R13
		end
	end

	assign adv     = s_r.en && (clocked_mode ? pre_tick : edge_hit); // R10
	assign hit     = adv && (s_r.count == s_r.reload); // R21
	assign wr_fire = avs_write && !s_r.waitreq;
	assign wr_dec  = rtc_decode(avs_address);
	assign rd_dec  = rtc_decode(avs_address);

	always_comb begin
		s_nxt     = s_r;
		s_nxt.irq = hit; // R1 R4

		// count: reload restarts at 0001H, otherwise wrap past FFFFH
		if (hit) begin
			s_nxt.count = `RTC_COUNT_RESTART; // R6 R8
		end else if (adv) begin
			s_nxt.count = 16'(s_r.count + 16'h0001); // R19 R16
		end
		if (hit && s_r.mode == rtc_pkg::RTC_ONE_SHOT) begin
			s_nxt.en = 1'b0; // R1
		end

		// idle: level follows the edge select bit; running: it moves only at reload,
		// so a polarity rewrite after a one-shot start shows as a lasting change
		if (!s_r.en) begin
			s_nxt.level = s_r.pol; // R15
		end else if (hit) begin
			s_nxt.level = !s_r.level; // R2 R5
		end
		s_nxt.tout = s_nxt.level; // R2 R5

		// bus writes land on the edge where waitrequest is seen low
		if (wr_fire && wr_dec[2]) begin
			case (wr_dec[1:0])
				2'h0: begin
					if (avs_byteenable[0]) begin
						s_nxt.en     = avs_writedata[`RTC_CTRL_EN];
						s_nxt.mode   = rtc_pkg::rtc_mode_t'(
							avs_writedata[`RTC_CTRL_MODE_HI:`RTC_CTRL_MODE_LO]);
						s_nxt.pol    = avs_writedata[`RTC_CTRL_POL];
						s_nxt.pre    = avs_writedata[`RTC_CTRL_PRE_HI:`RTC_CTRL_PRE_LO];
						s_nxt.out_en = avs_writedata[`RTC_CTRL_OUTEN];
					end
				end
				2'h1: begin
					s_nxt.count = rtc_merge16(s_r.count, avs_writedata, avs_byteenable);
				end
				2'h2: begin
					s_nxt.reload = rtc_merge16(s_r.reload, avs_writedata, avs_byteenable);
				end
				2'h3: begin
					if (avs_byteenable[0] && avs_writedata[`RTC_STAT_SEEN]) begin
						s_nxt.seen = 1'b0;
					end
				end
				default: begin
					s_nxt.seen = s_r.seen;
				end
			endcase
		end
		// a reload in the clearing cycle is kept
		if (hit) begin
			s_nxt.seen = 1'b1;
		end

		// one wait cycle, then answer; read data taken from current state
		if ((avs_read || avs_write) && s_r.waitreq) begin
			s_nxt.waitreq = 1'b0;
			s_nxt.rdata   = 32'h0000_0000;
			if (avs_read && rd_dec[2]) begin
				case (rd_dec[1:0])
					2'h0: begin
						s_nxt.rdata[`RTC_CTRL_EN]    = s_r.en;
						s_nxt.rdata[`RTC_CTRL_MODE_HI:`RTC_CTRL_MODE_LO] = s_r.mode;
						s_nxt.rdata[`RTC_CTRL_POL]   = s_r.pol;
						s_nxt.rdata[`RTC_CTRL_PRE_HI:`RTC_CTRL_PRE_LO] = s_r.pre;
						s_nxt.rdata[`RTC_CTRL_OUTEN] = s_r.out_en;
					end
					2'h1: begin
						s_nxt.rdata[15:0] = s_r.count; // R16
					end
					2'h2: begin
						s_nxt.rdata[15:0] = s_r.reload;
					end
					2'h3: begin
						s_nxt.rdata[`RTC_STAT_SEEN]  = s_r.seen;
						s_nxt.rdata[`RTC_STAT_LEVEL] = s_r.tout;
						s_nxt.rdata[`RTC_STAT_EN]    = s_r.en;
					end
					default: begin
						s_nxt.rdata = 32'h0000_0000;
					end
				endcase
			end
		end else begin
			s_nxt.waitreq = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_r.en      <= 1'b0;
			s_r.mode    <= rtc_pkg::RTC_ONE_SHOT;
			s_r.pol     <= 1'b0;
			s_r.pre     <= `RTC_PRE_RST;
			s_r.out_en  <= 1'b0;
			s_r.count   <= `RTC_COUNT_RST;
			s_r.reload  <= `RTC_RELOAD_RST;
			s_r.seen    <= 1'b0;
			s_r.level   <= 1'b0;
			s_r.tout    <= 1'b0;
			s_r.irq     <= 1'b0;
			s_r.waitreq <= 1'b1;
			s_r.rdata   <= 32'h0000_0000;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign avs_readdata    = s_r.rdata;
	assign avs_waitrequest = s_r.waitreq;
	assign timer_out       = s_r.tout;
	assign timer_out_oe    = s_r.out_en;
	assign timer_irq       = s_r.irq;

	oneshot_stop_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R1
		hit && s_r.mode == rtc_pkg::RTC_ONE_SHOT && !wr_fire
		|=> !s_r.en && s_r.irq && s_r.count == 16'h0001 ##1 !s_r.irq)
		else $error("one-shot reload did not stop the timer");

	oneshot_pulse_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R2
		hit && s_r.mode == rtc_pkg::RTC_ONE_SHOT && !wr_fire
		|=> s_r.tout != $past(s_r.tout) ##1 s_r.tout == s_r.pol)
		else $error("one-shot output pulse not exactly one cycle");

	run_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R5
		s_r.en && !hit |=> $stable(s_r.tout))
		else $error("output level moved between reloads");

	idle_level_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R15
		!s_r.en |=> s_r.tout == $past(s_r.pol))
		else $error("idle output level does not follow edge select");

	cont_reload_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R4
		hit && s_r.mode == rtc_pkg::RTC_CONTINUOUS && !wr_fire
		|=> s_r.en && s_r.irq && s_r.count == 16'h0001)
		else $error("continuous reload wrong");

	level_toggle_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R5
		hit && s_r.mode != rtc_pkg::RTC_ONE_SHOT && !wr_fire
		|=> s_r.tout != $past(s_r.tout))
		else $error("output did not toggle at reload");

	count_step_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R16
		adv && !hit && !wr_fire
		|=> s_r.count == 16'($past(s_r.count) + 16'h0001))
		else $error("count did not advance by one");

	count_wrap_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R19
		adv && s_r.count == 16'hffff && s_r.reload != 16'hffff && !wr_fire
		|=> s_r.count == 16'h0000)
		else $error("count did not wrap to zero");

	presc_space_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R7
		adv && clocked_mode && s_r.pre != 3'h0 && $stable(s_r.pre) |=> !adv)
		else $error("prescaled count advanced on back-to-back clocks");

	edge_step_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R10
		s_r.en && s_r.mode == rtc_pkg::RTC_COUNTER && s_r.pol &&
		$past(timer_in, 2) && !$past(timer_in, 3) |-> adv)
		else $error("qualifying edge did not advance count");

	idle_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n) // R1
		!s_r.en && !wr_fire |=> $stable(s_r.count))
		else $error("count moved while disabled");

	bus_wait_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(avs_read || avs_write) && s_r.waitreq |=> !s_r.waitreq ##1 s_r.waitreq)
		else $error("waitrequest not low for exactly one cycle");

endmodule

// >>> verification/rtc_pin_model.sv
// far-side model: timer input pin and comparator output
// assumes the bench calls flip() just after a rising clock edge
`timescale 1ns/1ps
module rtc_pin_model (
	input  wire logic clock,
	output logic      timer_in,
	output logic      cmp_out
);
	initial begin
		timer_in = 1'b0;
		cmp_out  = 1'b0;
	end

	// each level held four clocks: edges never come faster than a quarter clock
	task flip(input logic sel, input int n);
		repeat (n) begin
			repeat (4) @(posedge clock);
			if (sel) begin
				cmp_out <= ~cmp_out;
			end else begin
				timer_in <= ~timer_in;
			end
		end
	endtask
endmodule

// >>> verification/test_rtc_timer.sv
// bench for the reloadable timer: bus tasks and mode scenarios
// assumes rtc_timer and the pin model; byte lanes 0 and 1 always enabled
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module test_rtc_timer;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic        rd    = 1'b0;
	logic        wr    = 1'b0;
	logic [31:0] wdat  = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic        tin;
	logic        cmpo;
	logic        tout;
	logic        toe;
	logic        irq;
	logic [31:0] q;
	logic        tout_d = 1'b0;
	int          fail_count = 0;
	int          cmp_count  = 0;
	int          cyc   = 0;
	int          irq_n = 0;
	int          tog_n = 0;
	int          hi_n  = 0;
	int          last  = 0;
	int          gap   = 0;
	int          i0;
	int          t0;
	int          h0;

	rtc_timer rtc_timer_inst (
		.clock           (clock),
		.rst_n           (rst_n),
		.avs_address     (adr),
		.avs_read        (rd),
		.avs_write       (wr),
		.avs_writedata   (wdat),
		.avs_byteenable  (4'h3),
		.avs_readdata    (rdat),
		.avs_waitrequest (wreq),
		.timer_in        (tin),
		.cmp_out         (cmpo),
		.timer_out       (tout),
		.timer_out_oe    (toe),
		.timer_irq       (irq)
	);

	rtc_pin_model rtc_pin_model_inst (
		.clock    (clock),
		.timer_in (tin),
		.cmp_out  (cmpo)
	);

	always #4 clock = ~clock;

	task print_verdict();
		$display("mismatches %0d, compares %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// pulse and toggle counters; only differences across a scenario matter
	always @(posedge clock) begin
		cyc <= cyc + 1;
		tout_d <= tout;
		if (tout !== tout_d) tog_n <= tog_n + 1;
		if (tout === 1'b1) hi_n <= hi_n + 1;
		if (irq === 1'b1) begin
			irq_n <= irq_n + 1;
			gap <= cyc - last;
			last <= cyc;
		end
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			print_verdict();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one transfer; the extra edge keeps requests from merging back to back
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= ~w;
		@(posedge clock);
		while (wreq !== 1'b0) @(posedge clock);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clock);
	endtask

	task cfg(input logic [7:0] c, input logic [15:0] s, input logic [15:0] r);
		xfer(1'b1, `RTC_OFF_CTRL, {24'h0, c & 8'hfe});
		xfer(1'b1, `RTC_OFF_COUNT, {16'h0, s});
		xfer(1'b1, `RTC_OFF_RELOAD, {16'h0, r});
		xfer(1'b1, `RTC_OFF_CTRL, {24'h0, c});
	endtask

	task snap();
		i0 = irq_n;
		t0 = tog_n;
		h0 = hi_n;
	endtask

	task wait_irq(input int n);
		while (irq_n < i0 + n) @(posedge clock);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		// reset values, the last one an unmapped word
		for (int k = 0; k < 5; k++) begin
			xfer(1'b0, 8'(k * 4), 32'h0);
			chk(q, 32'h0);
		end
		// start at 2 so a later pass from the written start shows up as a short gap
		for (int p = 0; p < 8; p += 7) begin
			cfg({1'b1, 3'(p), 4'b0011}, 16'h0002, 16'h0003);
			snap();
			wait_irq(3);
			chk(gap, 3 << p);
			chk(tog_n - t0, irq_n - i0);
			xfer(1'b1, `RTC_OFF_CTRL, 32'h0);
		end
		// one-shot across the top of the count range
		cfg(8'h81, 16'hfffe, 16'h0001);
		snap();
		wait_irq(1);
		repeat (20) @(posedge clock);
		chk(irq_n - i0, 1);
		chk(hi_n - h0, 1);
		chk(tog_n - t0, 2);
		xfer(1'b0, `RTC_OFF_CTRL, 32'h0);
		chk(q & 32'h1, 32'h0);
		xfer(1'b0, `RTC_OFF_COUNT, 32'h0);
		chk(q & 32'hffff, 32'h1);
		// lasting one-shot level: start high, rewrite polarity low once running
		cfg(8'h89, 16'h0001, 16'h0040);
		xfer(1'b1, `RTC_OFF_CTRL, 32'h81);
		snap();
		wait_irq(1);
		repeat (20) @(posedge clock);
		chk(tout, 32'h0);
		chk(tog_n - t0, 1);
		chk(toe, 32'h1);
		// counter mode, rising edges: five flips give three rises
		cfg(8'h8d, 16'h0001, 16'h0009);
		xfer(1'b0, `RTC_OFF_STATUS, 32'h0);
		chk((q >> 1) & 32'h1, 32'h1);
		rtc_pin_model_inst.flip(1'b0, 5);
		repeat (8) @(posedge clock);
		xfer(1'b0, `RTC_OFF_COUNT, 32'h0);
		chk(q & 32'hffff, 32'h4);
		// comparator mode, falling edges: five flips give two falls
		cfg(8'h87, 16'h0001, 16'h0002);
		snap();
		xfer(1'b0, `RTC_OFF_STATUS, 32'h0);
		chk((q >> 1) & 32'h1, 32'h0);
		rtc_pin_model_inst.flip(1'b1, 5);
		repeat (8) @(posedge clock);
		chk(irq_n - i0, 1);
		xfer(1'b0, `RTC_OFF_COUNT, 32'h0);
		chk(q & 32'hffff, 32'h1);
		xfer(1'b0, `RTC_OFF_STATUS, 32'h0);
		chk((q >> 1) & 32'h1, 32'h1);
		chk(q & 32'h5, 32'h5);
		xfer(1'b1, `RTC_OFF_STATUS, 32'h1);
		xfer(1'b0, `RTC_OFF_STATUS, 32'h0);
		chk(q & 32'h1, 32'h0);
		print_verdict();
	end
endmodule
